/* File: field_map_pkg.sv */
package field_map_pkg;

    // byte-wide serial access
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // replicated register block: base plus instance times stride
    localparam logic [7:0] BLK_BASE = 8'h10;
    localparam logic [7:0] BLK_STRIDE = 8'h08;
    localparam int NUM_INST = 2;

    // layout of one block instance
    localparam int BLK_BYTES = 8;
    localparam int BOFF_W = 3;
    localparam int NUM_FIELDS = 3;
    localparam int FIELD_W = 2;

    // owning field of each byte offset, index 7 first
    localparam logic [7:0][1:0] BYTE_FIELD = {
        2'h0, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0
    };
    // byte 7 is reserved
    localparam logic [7:0] BYTE_MAPPED = 8'h7F;
    // field 0 is an atomic half-word, field 1 a plain word, field 2 a byte
    localparam logic [2:0] FIELD_ATOMIC = 3'h1;
    // offset of the most significant byte of each field, index 2 first
    localparam logic [2:0][2:0] FIELD_TOP = {3'h6, 3'h5, 3'h1};

    // reset values
    localparam logic [7:0] FIELD_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_RD = 8'h00;

endpackage : field_map_pkg

/* File: field_decode_if.sv */
`timescale 1ns/1ps
interface field_decode_if #(
    parameter int NI = field_map_pkg::NUM_INST
);
    import field_map_pkg::*;
    localparam int IW = (NI > 1) ? $clog2(NI) : 1;

    logic [ADDR_W-1:0] addr;
    logic hit;
    logic [IW-1:0] inst;
    logic [BOFF_W-1:0] boff;
    logic [FIELD_W-1:0] field;
    logic atomic;
    logic top;

    modport dec (
        input addr,
        output hit, inst, boff, field, atomic, top
    );
    modport use_side (
        output addr,
        input hit, inst, boff, field, atomic, top
    );
endinterface : field_decode_if

/* File: field_decoder.sv */
`timescale 1ns/1ps
module field_decoder #(
    parameter int NI = field_map_pkg::NUM_INST
) (
    field_decode_if.dec d
);
    import field_map_pkg::*;
    localparam int IW = (NI > 1) ? $clog2(NI) : 1;

    always_comb begin
        int rel;
        logic [BOFF_W-1:0] b;
        rel = 0;
        b = '0;
        d.hit = 1'b0;
        d.inst = '0;
        d.boff = '0;
        d.field = '0;
        d.atomic = 1'b0;
        d.top = 1'b0;
        // instance k answers at base + k * stride
        for (int k = 0; k < NI; k++) begin
            rel = int'(d.addr) - (int'(BLK_BASE) + k * int'(BLK_STRIDE));
            b = rel[BOFF_W-1:0];
            if (rel >= 0 && rel < BLK_BYTES && BYTE_MAPPED[b]) begin
                d.hit = 1'b1;
                d.inst = IW'(k);
                d.boff = b;
                d.field = BYTE_FIELD[b];
                d.atomic = FIELD_ATOMIC[BYTE_FIELD[b]];
                d.top = (b == FIELD_TOP[BYTE_FIELD[b]]);
            end
        end
    end
endmodule : field_decoder

/* File: multibyte_field_write_logic.sv */
`timescale 1ns/1ps
module multibyte_field_write_logic #(
    parameter int NI = field_map_pkg::NUM_INST
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic [field_map_pkg::ADDR_W-1:0] wr_addr_i,
    input wire logic [field_map_pkg::DATA_W-1:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [field_map_pkg::ADDR_W-1:0] rd_addr_i,
    output logic [field_map_pkg::DATA_W-1:0] rd_data_o,
    output logic rd_valid_o,
    output logic wr_miss_o,
    output logic [NI*field_map_pkg::BLK_BYTES*8-1:0] applied_o,
    output logic [NI*field_map_pkg::NUM_FIELDS-1:0] upd_o,
    output logic [NI*field_map_pkg::NUM_FIELDS-1:0] stage_pend_o
);
    import field_map_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [NI-1:0][BLK_BYTES-1:0][7:0] applied;
        logic [NI-1:0][BLK_BYTES-1:0][7:0] stage;
        logic [NI-1:0][NUM_FIELDS-1:0] pend;
        logic [NI-1:0][NUM_FIELDS-1:0] upd;
        logic miss;
        logic [DATA_W-1:0] rd_data;
        logic rd_valid;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // address decode for both ports

    field_decode_if #(.NI(NI)) wd ();
    field_decode_if #(.NI(NI)) rdd ();

    assign wd.addr = wr_addr_i;
    assign rdd.addr = rd_addr_i;

    field_decoder #(.NI(NI)) u_wr_dec (
        .d(wd)
    );
    field_decoder #(.NI(NI)) u_rd_dec (
        .d(rdd)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_nxt = st_r;
        st_nxt.upd = '0;
        st_nxt.miss = 1'b0;
        st_nxt.rd_valid = 1'b0;
        if (wr_en_i) begin
            if (!wd.hit) begin
                st_nxt.miss = 1'b1;
            end else if (!wd.atomic) begin
                // byte goes live without waiting for its neighbours
                st_nxt.applied[wd.inst][wd.boff] = wr_data_i;
                st_nxt.upd[wd.inst][wd.field] = 1'b1;
            end else if (!wd.top) begin
                // hold until the top byte arrives
                st_nxt.stage[wd.inst][wd.boff] = wr_data_i;
                st_nxt.pend[wd.inst][wd.field] = 1'b1;
            end else begin
                // staged low bytes and new top byte land together
                for (int b = 0; b < BLK_BYTES; b++) begin
                    if (BYTE_MAPPED[b] && BYTE_FIELD[b] == wd.field) begin
                        if (BOFF_W'(b) == wd.boff) begin
                            st_nxt.applied[wd.inst][b] = wr_data_i;
                        end else begin
                            st_nxt.applied[wd.inst][b] =
                                st_r.stage[wd.inst][b];
                        end
                    end
                end
                st_nxt.upd[wd.inst][wd.field] = 1'b1;
                st_nxt.pend[wd.inst][wd.field] = 1'b0;
            end
        end
        if (rd_en_i) begin
            st_nxt.rd_valid = 1'b1;
            // reads show the live value, not the staging buffer
            if (rdd.hit) begin
                st_nxt.rd_data = st_r.applied[rdd.inst][rdd.boff];
            end else begin
                st_nxt.rd_data = UNMAPPED_RD;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_r.applied <= {NI * BLK_BYTES{FIELD_RST}};
            st_r.stage <= {NI * BLK_BYTES{FIELD_RST}};
            st_r.pend <= '0;
            st_r.upd <= '0;
            st_r.miss <= 1'b0;
            st_r.rd_data <= UNMAPPED_RD;
            st_r.rd_valid <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    genvar gi;
    generate
        for (gi = 0; gi < NI; gi++) begin : g_inst
            // bit 0 of each slice is bit 0 of byte offset 0
            assign applied_o[gi*BLK_BYTES*8 +: BLK_BYTES*8] =
                st_r.applied[gi];
            assign upd_o[gi*NUM_FIELDS +: NUM_FIELDS] = st_r.upd[gi];
            assign stage_pend_o[gi*NUM_FIELDS +: NUM_FIELDS] = st_r.pend[gi];
        end
    endgenerate

    assign rd_data_o = st_r.rd_data;
    assign rd_valid_o = st_r.rd_valid;
    assign wr_miss_o = st_r.miss;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    a_bit_order: assert property (
        wr_en_i && wr_addr_i == BLK_BASE + 8'h02
        |=> applied_o[23:16] == $past(wr_data_i)
    ) else $error("field bit numbering is not lsb first");

    a_byte_place: assert property (
        wr_en_i && wd.hit && !wd.atomic ##1 rd_en_i &&
            rd_addr_i == $past(wr_addr_i) && !wr_en_i
        |=> rd_valid_o && rd_data_o == $past(wr_data_i, 2)
    ) else $error("byte did not land at its own address");

    a_atomic_hold: assert property (
        wr_en_i && wd.hit && wd.atomic && !wd.top
        |=> $stable(st_r.applied) && upd_o == '0
    ) else $error("atomic low byte reached internal logic");

    a_atomic_apply: assert property (
        wr_en_i && wd.hit && wd.atomic && wd.top && wd.inst == '0
        |=> st_r.applied[0][1] == $past(wr_data_i) &&
            st_r.applied[0][0] == $past(st_r.stage[0][0]) &&
            upd_o[0]
    ) else $error("atomic field not applied whole on top byte");

    a_plain_apply: assert property (
        wr_en_i && wd.hit && !wd.atomic
        |=> st_r.applied[$past(wd.inst)][$past(wd.boff)] ==
            $past(wr_data_i) && upd_o != '0
    ) else $error("non-atomic byte not applied at once");

    a_inst_stride: assert property (
        wr_en_i && wr_addr_i == BLK_BASE + BLK_STRIDE
        |-> wd.hit && wd.inst == 1 && wd.boff == '0
    ) else $error("second instance not at base plus stride");

    a_miss_pulse: assert property (
        wr_en_i && !wd.hit |=> wr_miss_o && $stable(st_r.applied)
    ) else $error("unmapped write not flagged");

    a_refused_hold: assert property (
        wr_en_i && !wd.hit
        |=> upd_o == '0 && $stable(st_r.stage) && $stable(st_r.pend)
    ) else $error("unmapped write changed field state");

    a_pend_set: assert property (
        wr_en_i && wd.hit && wd.atomic && !wd.top
        |=> stage_pend_o[$past(wd.inst) * NUM_FIELDS + $past(wd.field)]
    ) else $error("staged low byte not marked pending");

    a_pend_clear: assert property (
        wr_en_i && wd.hit && wd.atomic && wd.top
        |=> !stage_pend_o[$past(wd.inst) * NUM_FIELDS + $past(wd.field)]
    ) else $error("top byte write left field pending");

    a_top_only: assert property (
        upd_o[0] |-> $past(wr_en_i) && $past(wd.top) && $past(wd.inst) == '0
    ) else $error("atomic field updated without its top byte");

    a_upd_single: assert property (
        $onehot0(upd_o)
    ) else $error("more than one field updated at once");

    a_idle_quiet: assert property (
        !wr_en_i |=> upd_o == '0 && !wr_miss_o && $stable(st_r.applied)
    ) else $error("field state changed with no write");

    a_read_pulse: assert property (
        rd_en_i |=> rd_valid_o
    ) else $error("read not answered in the next cycle");

    a_read_idle: assert property (
        !rd_en_i |=> !rd_valid_o
    ) else $error("read valid without a read");

    a_rd_unmapped: assert property (
        rd_en_i && !rdd.hit |=> rd_data_o == UNMAPPED_RD
    ) else $error("unmapped read did not return the fill value");

endmodule : multibyte_field_write_logic

/* File: host_port_model.sv */
`timescale 1ns/1ps
module host_port_model (
    input wire logic clk_i,
    input wire logic [7:0] rd_data_i,
    input wire logic rd_valid_i,
    output logic wr_en_o,
    output logic [7:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    output logic rd_en_o,
    output logic [7:0] rd_addr_o
);
    initial begin
        wr_en_o = 1'b0;
        wr_addr_o = 8'h00;
        wr_data_o = 8'h00;
        rd_en_o = 1'b0;
        rd_addr_o = 8'h00;
    end
    // entered at a falling edge; hold keeps strobe up for the next byte
    task wr_byte(input logic [7:0] a, input logic [7:0] d, input bit hold);
        wr_en_o = 1'b1;
        wr_addr_o = a;
        wr_data_o = d;
        @(posedge clk_i);
        @(negedge clk_i);
        if (!hold) begin
            wr_en_o = 1'b0;
            wr_addr_o = ~a;
            wr_data_o = ~d;
        end
    endtask : wr_byte
    // low byte first, top byte straight after
    task wr_pair(input logic [7:0] a, input logic [15:0] v);
        wr_byte(a, v[7:0], 1'b1);
        wr_byte(a + 8'h01, v[15:8], 1'b0);
    endtask : wr_pair
    task rd_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
        rd_en_o = 1'b1;
        rd_addr_o = a;
        @(posedge clk_i);
        @(negedge clk_i);
        d = rd_data_i;
        v = rd_valid_i;
        rd_en_o = 1'b0;
        rd_addr_o = ~a;
    endtask : rd_byte
endmodule : host_port_model

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
    import field_map_pkg::*;
    typedef struct {
        logic [7:0] a;
        logic [7:0] d;
        logic [5:0] u;
        logic m;
    } row_t;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, wr_en, rd_en, rd_valid, wr_miss;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data, d;
    logic [127:0] applied;
    logic [5:0] upd, pend;
    logic v;
    int fails = 0, check_count = 0;
    row_t rows[9] = '{'{8'h12, 8'hA1, 6'h02, 0}, '{8'h15, 8'h3E, 6'h02, 0},
        '{8'h16, 8'h7E, 6'h04, 0}, '{8'h1A, 8'h5A, 6'h10, 0},
        '{8'h1E, 8'h81, 6'h20, 0}, '{8'h17, 8'hFF, 6'h00, 1},
        '{8'h1F, 8'hFF, 6'h00, 1}, '{8'h20, 8'h11, 6'h00, 1},
        '{8'h0F, 8'h22, 6'h00, 1}};
    always #20 clk_sys_i = ~clk_sys_i;
    host_port_model host (.clk_i(clk_sys_i), .rd_data_i(rd_data),
        .rd_valid_i(rd_valid), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
        .wr_data_o(wr_data), .rd_en_o(rd_en), .rd_addr_o(rd_addr));
    multibyte_field_write_logic #(.NI(2)) dut (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .wr_en_i(wr_en), .wr_addr_i(wr_addr),
        .wr_data_i(wr_data), .rd_en_i(rd_en), .rd_addr_i(rd_addr),
        .rd_data_o(rd_data), .rd_valid_o(rd_valid), .wr_miss_o(wr_miss),
        .applied_o(applied), .upd_o(upd), .stage_pend_o(pend));
    ////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [127:0] seen, input logic [127:0] e);
        check_count++;
        if (seen !== e) begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", n, e, seen);
        end
    endtask : chk
    task stop_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #80000;
        fails++;
        stop_test;
    end
    initial begin
        repeat (20) @(negedge clk_sys_i);
        chk("applied in reset", applied, 128'h0);
        chk("flags in reset", {upd, pend, rd_valid, wr_miss, rd_data}, 22'h0);
        rst_n_i = 1'b1;
        @(negedge clk_sys_i);
        $display("test reset done");
        foreach (rows[i]) begin
            host.wr_byte(rows[i].a, rows[i].d, 1'b0);
            chk("wr_miss", wr_miss, rows[i].m);
            chk("upd", upd, rows[i].u);
            host.rd_byte(rows[i].a, d, v);
            chk("rd_valid", v, 1'b1);
            chk("rd_data", d, rows[i].m ? UNMAPPED_RD : rows[i].d);
        end
        $display("test rows done");
        host.wr_byte(8'h18, 8'h4D, 1'b0);
        chk("pend low", pend, 6'h08);
        chk("held bytes", applied[79:64], 16'h0);
        chk("upd low", upd, 6'h00);
        host.rd_byte(8'h18, d, v);
        chk("staged read", d, FIELD_RST);
        host.wr_byte(8'h19, 8'hB3, 1'b0);
        chk("atomic apply", applied[79:64], 16'hB34D);
        chk("upd top", upd, 6'h08);
        chk("pend top", pend, 6'h00);
        @(negedge clk_sys_i);
        chk("upd drop", upd, 6'h00);
        host.wr_pair(8'h10, 16'h5AC1);
        chk("pair apply", applied[15:0], 16'h5AC1);
        chk("pair lsb", applied[0], 1'b1);
        chk("upd pair", upd, 6'h01);
        chk("word byte", applied[47:40], 8'h3E);
        $display("test atomic done");
        @(negedge clk_sys_i);
        host.wr_byte(8'h10, 8'h77, 1'b0);
        chk("pend before reset", pend, 6'h01);
        rst_n_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        chk("applied mid reset", applied, 128'h0);
        chk("flags mid reset", {upd, pend, rd_valid, wr_miss}, 14'h0);
        rst_n_i = 1'b1;
        @(negedge clk_sys_i);
        host.wr_byte(8'h11, 8'h12, 1'b0);
        chk("top after reset", applied[15:0], 16'h1200);
        host.rd_byte(8'h12, d, v);
        chk("read after reset", d, FIELD_RST);
        $display("test mid reset done");
        stop_test;
    end
endmodule : tb
